// file: common/skp_cfg.svh
// Constants for the text command parser
`ifndef SKP_CFG_SVH
`define SKP_CFG_SVH
`define SKP_CH_NL     8'h0A
`define SKP_CH_SPACE  8'h20
`define SKP_CH_PLUS   8'h2B
`define SKP_CH_MINUS  8'h2D
`define SKP_CH_DOT    8'h2E
`define SKP_CH_COLON  8'h3A
`define SKP_CH_SEMI   8'h3B
`define SKP_CH_QMARK  8'h3F
`define SKP_KW_MAX    4'hC
`define SKP_DEPTH_MAX 2'h3
`define SKP_EQ_DEPTH  3'h4
`define SKP_ERR_SYNTAX 8'h01
`define SKP_ERR_HEADER 8'h02
`define SKP_ERR_QUERY  8'h03
`define SKP_ERR_DATA   8'h04
`define SKP_ERR_CAL    8'h05
`define SKP_CAL_CODE   16'h04D2
`define SKP_CAL_EXIT   16'h0000
`endif

// file: common/skp_kw_if.sv
// Keyword buffer handed to the matcher and its verdict
`timescale 1ns/1ns
interface skp_kw_if;
  logic [11:0][7:0] chars;
  logic [3:0]       len;
  logic             hit;
  skp_pkg::skp_kw_t idx;

  modport parser  (output chars, output len, input hit, input idx);
  modport matcher (input chars, input len, output hit, output idx);
endinterface : skp_kw_if

// file: common/skp_pkg.sv
// Types and character helpers for the text command parser
package skp_pkg;
  typedef enum logic [3:0] {
    KW_NONE = 4'h0, KW_CAL  = 4'h1, KW_VOLT = 4'h2, KW_CURR = 4'h3,
    KW_MEAS = 4'h4, KW_LEV  = 4'h5, KW_OUTP = 4'h6, KW_STAT = 4'h7,
    KW_SYST = 4'h8, KW_TRIG = 4'h9, KW_MODE = 4'hA, KW_SAVE = 4'hB,
    KW_ERR  = 4'hC
  } skp_kw_t;

  typedef enum logic [2:0] {
    ST_UNIT = 3'b000, ST_KWS = 3'b001, ST_KW   = 3'b010, ST_QRY = 3'b011,
    ST_PAR0 = 3'b100, ST_PAR = 3'b101, ST_SKIP = 3'b110
  } skp_st_t;

  typedef enum logic [1:0] {
    PAR_NONE = 2'b00, PAR_NUM = 2'b01, PAR_STR = 2'b10
  } skp_par_t;

  typedef struct packed {
    skp_st_t          st;
    logic [11:0][7:0] kbuf;
    logic [3:0]       klen;
    logic [2:0][3:0]  path;
    logic [1:0]       depth;
    logic [1:0]       base;
    logic             query;
    skp_par_t         pkind;
    logic [15:0]      num;
    logic             term_pend;
    logic             rx_ready;
    logic             cmd_valid;
    logic [2:0][3:0]  cmd_path;
    logic [1:0]       cmd_len;
    logic             cmd_query;
    skp_par_t         cmd_pkind;
    logic [15:0]      cmd_num;
    logic             cal_mode;
    logic             cal_store;
    logic [3:0][7:0]  eq;
    logic [2:0]       ecnt;
  } skp_state_t;

  function automatic logic skp_is_letter(input logic [7:0] c);
    return (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A);
  endfunction : skp_is_letter

  function automatic logic skp_is_digit(input logic [7:0] c);
    return c >= 8'h30 && c <= 8'h39;
  endfunction : skp_is_digit

  function automatic logic [7:0] skp_to_upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction : skp_to_upper
endpackage : skp_pkg

// file: design/skp_kw_match.sv
// Keyword table lookup accepting exact short or complete long forms
`timescale 1ns/1ns
`include "skp_cfg.svh"
module skp_kw_match (
  // Buffered keyword in, verdict out
  skp_kw_if.matcher kw
);
  // Long forms right-aligned: first letter sits in byte len-1
  function automatic logic [95:0] kw_long(input logic [3:0] k);
    case (k)
      4'h1:    return 96'("CALIBRATE");
      4'h2:    return 96'("VOLTAGE");
      4'h3:    return 96'("CURRENT");
      4'h4:    return 96'("MEASURE");
      4'h5:    return 96'("LEVEL");
      4'h6:    return 96'("OUTPUT");
      4'h7:    return 96'("STATUS");
      4'h8:    return 96'("SYSTEM");
      4'h9:    return 96'("TRIGGER");
      4'hA:    return 96'("MODE");
      4'hB:    return 96'("SAVE");
      4'hC:    return 96'("ERROR");
      default: return 96'h0;
    endcase
  endfunction : kw_long

  function automatic logic [3:0] kw_len(input logic [3:0] k);
    case (k)
      4'h1:                      return 4'h9;
      4'h2, 4'h3, 4'h4, 4'h9:    return 4'h7;
      4'h5, 4'hC:                return 4'h5;
      4'h6, 4'h7, 4'h8:          return 4'h6;
      4'hA, 4'hB:                return 4'h4;
      default:                   return 4'h0;
    endcase
  endfunction : kw_len

  function automatic logic is_vowel(input logic [7:0] c);
    return c == 8'h41 || c == 8'h45 || c == 8'h49 || c == 8'h4F ||
           c == 8'h55;
  endfunction : is_vowel

  logic [95:0] lf;
  logic [3:0]  ll;
  logic [3:0]  sl;
  logic        same;

  always_comb begin
    kw.hit = 1'b0;
    kw.idx = skp_pkg::KW_NONE;
    lf     = '0;
    ll     = '0;
    sl     = '0;
    same   = 1'b0;
    for (int k = 1; k <= 12; k++) begin
      lf = kw_long(4'(k));
      ll = kw_len(4'(k));
      // Short form: whole word up to four letters, else three or four
      if (ll <= 4'h4)
        sl = ll;
      else if (is_vowel(lf[8*(ll-4'h4) +: 8]))
        sl = 4'h3;
      else
        sl = 4'h4;
      same = (kw.len == sl) || (kw.len == ll);
      for (int i = 0; i < 12; i++) begin
        if (4'(i) < kw.len && kw.chars[i] != lf[8*(ll-4'(i)-4'h1) +: 8])
          same = 1'b0;
      end
      if (same && !kw.hit) begin
        kw.hit = 1'b1;
        kw.idx = skp_pkg::skp_kw_t'(4'(k));
      end
    end
  end
endmodule : skp_kw_match

// file: design/skp_parser.sv
// Program message parser: units, keywords, query, data, calibration gate
//
// What this block does
// - Units end at newline or end-of-line character.
// - One numeric or string parameter after space.
// - Keywords accepted in short or long form.
// - Short form: whole, four, or three letters.
// - Any other keyword spelling is an error.
// - Keyword letters compared without regard to case.
// - Colon separates keywords; leading colon means root.
// - Question mark only after last keyword: query.
// - Calibration needs access code; then save strobe.
// - Semicolon separates message units.
// - Newline 0A is the message terminator.
// - Terminator or root specifier returns to root.
`timescale 1ns/1ns
`include "skp_cfg.svh"
module skp_parser (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Character stream from the port
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_eol,
  output logic             rx_ready,
  // Decoded command
  output logic             cmd_valid,
  output logic [11:0]      cmd_path,
  output logic [1:0]       cmd_len,
  output logic             cmd_query,
  output logic [1:0]       cmd_par_kind,
  output logic [15:0]      cmd_par_num,
  // Calibration
  output logic             cal_mode,
  output logic             cal_store,
  // Error queue
  input  wire logic        err_pop,
  output logic [2:0]       err_count,
  output logic [7:0]       err_head
);
  skp_pkg::skp_state_t r_ff;
  skp_pkg::skp_state_t nxt_r;
  skp_kw_if            kw ();

  skp_kw_match u_match (
    .kw (kw.matcher)
  );

  assign kw.chars = r_ff.kbuf;
  assign kw.len   = r_ff.klen;

  logic       act;
  logic [7:0] c;
  logic [7:0] up;
  logic       is_nl;
  logic       is_semi;
  logic       is_col;
  logic       close_kw;
  logic       fin;
  logic       emit;
  logic       fail;
  logic [7:0] errc;

  always_comb begin
    nxt_r           = r_ff;
    nxt_r.cmd_valid = 1'b0;
    nxt_r.cal_store = 1'b0;
    close_kw        = 1'b0;
    fin             = 1'b0;
    emit            = 1'b0;
    fail            = 1'b0;
    errc            = `SKP_ERR_SYNTAX;
    // A character flagged end-of-line is followed by a terminator
    act = r_ff.term_pend || (rx_valid && r_ff.rx_ready);
    c   = r_ff.term_pend ? `SKP_CH_NL : rx_char;
    up  = skp_pkg::skp_to_upper(c);
    is_nl   = c == `SKP_CH_NL;
    is_semi = c == `SKP_CH_SEMI;
    is_col  = c == `SKP_CH_COLON;
    if (act) begin
      nxt_r.term_pend = !r_ff.term_pend && rx_eol && !is_nl;
      case (r_ff.st)
        skp_pkg::ST_UNIT: begin
          if (is_col) begin
            nxt_r.depth = 2'h0;
            nxt_r.st    = skp_pkg::ST_KWS;
          end else if (skp_pkg::skp_is_letter(c)) begin
            nxt_r.kbuf[0] = up;
            nxt_r.klen    = 4'h1;
            nxt_r.st      = skp_pkg::ST_KW;
          end else if (!(is_nl || is_semi)) begin
            fail = 1'b1;
          end
        end
        skp_pkg::ST_KWS: begin
          if (skp_pkg::skp_is_letter(c)) begin
            nxt_r.kbuf[0] = up;
            nxt_r.klen    = 4'h1;
            nxt_r.st      = skp_pkg::ST_KW;
          end else begin
            fail = 1'b1;
          end
        end
        skp_pkg::ST_KW: begin
          if (skp_pkg::skp_is_letter(c)) begin
            if (r_ff.klen == `SKP_KW_MAX) begin
              fail = 1'b1;
              errc = `SKP_ERR_HEADER;
            end else begin
              nxt_r.kbuf[r_ff.klen] = up;
              nxt_r.klen = r_ff.klen + 4'h1;
            end
          end else if (is_col) begin
            close_kw = 1'b1;
            nxt_r.st = skp_pkg::ST_KWS;
          end else if (c == `SKP_CH_QMARK) begin
            close_kw    = 1'b1;
            nxt_r.query = 1'b1;
            nxt_r.st    = skp_pkg::ST_QRY;
          end else if (c == `SKP_CH_SPACE) begin
            close_kw = 1'b1;
            nxt_r.st = skp_pkg::ST_PAR0;
          end else if (is_nl || is_semi) begin
            close_kw = 1'b1;
            fin      = 1'b1;
          end else begin
            fail = 1'b1;
          end
        end
        skp_pkg::ST_QRY: begin
          if (c == `SKP_CH_SPACE) begin
            nxt_r.st = skp_pkg::ST_PAR0;
          end else if (is_nl || is_semi) begin
            fin = 1'b1;
          end else begin
            fail = 1'b1;
            errc = `SKP_ERR_QUERY;
          end
        end
        skp_pkg::ST_PAR0: begin
          if (skp_pkg::skp_is_digit(c)) begin
            nxt_r.num   = {8'h00, c - 8'h30};
            nxt_r.pkind = skp_pkg::PAR_NUM;
            nxt_r.st    = skp_pkg::ST_PAR;
          end else if (c == `SKP_CH_PLUS || c == `SKP_CH_MINUS ||
                       c == `SKP_CH_DOT) begin
            nxt_r.pkind = skp_pkg::PAR_NUM;
            nxt_r.st    = skp_pkg::ST_PAR;
          end else if (skp_pkg::skp_is_letter(c)) begin
            nxt_r.pkind = skp_pkg::PAR_STR;
            nxt_r.st    = skp_pkg::ST_PAR;
          end else if (is_nl || is_semi) begin
            fin = 1'b1;
          end else if (c != `SKP_CH_SPACE) begin
            fail = 1'b1;
            errc = `SKP_ERR_DATA;
          end
        end
        skp_pkg::ST_PAR: begin
          if (is_nl || is_semi) begin
            fin = 1'b1;
          end else if (r_ff.pkind == skp_pkg::PAR_NUM &&
                       skp_pkg::skp_is_digit(c)) begin
            nxt_r.num = 16'(r_ff.num * 16'd10 + {8'h00, c - 8'h30});
          end
        end
        skp_pkg::ST_SKIP: begin
          nxt_r.st = skp_pkg::ST_SKIP;
        end
        default: begin
          nxt_r.st = skp_pkg::ST_SKIP;
        end
      endcase

      if (close_kw) begin
        if (!kw.hit || r_ff.depth == `SKP_DEPTH_MAX) begin
          fail = 1'b1;
          errc = `SKP_ERR_HEADER;
        end else begin
          nxt_r.path[r_ff.depth] = kw.idx;
          nxt_r.depth = r_ff.depth + 2'h1;
        end
      end

      // Calibration commands other than the CAL query are gated by the access code
      if (fin && !fail) begin
        emit = 1'b1;
        if (nxt_r.path[0] == skp_pkg::KW_CAL) begin
          if (nxt_r.depth == 2'h1) begin
            if (nxt_r.query) begin
              emit = 1'b1;
            end else if (nxt_r.pkind == skp_pkg::PAR_NUM &&
                         nxt_r.num == `SKP_CAL_CODE) begin
              nxt_r.cal_mode = 1'b1;
            end else if (r_ff.cal_mode && nxt_r.pkind == skp_pkg::PAR_NUM &&
                         nxt_r.num == `SKP_CAL_EXIT) begin
              nxt_r.cal_mode = 1'b0;
            end else begin
              fail = 1'b1;
            end
          end else if (!r_ff.cal_mode) begin
            fail = 1'b1;
          end else if (nxt_r.path[1] == skp_pkg::KW_SAVE &&
                       nxt_r.depth == 2'h2 && !nxt_r.query) begin
            nxt_r.cal_store = 1'b1;
          end
          if (fail) begin
            emit = 1'b0;
            errc = `SKP_ERR_CAL;
          end
        end
      end

      if (emit) begin
        nxt_r.cmd_valid = 1'b1;
        nxt_r.cmd_path  = nxt_r.path;
        nxt_r.cmd_len   = nxt_r.depth;
        nxt_r.cmd_query = nxt_r.query;
        nxt_r.cmd_pkind = nxt_r.pkind;
        nxt_r.cmd_num   = nxt_r.num;
      end

      if (is_nl || is_semi) begin
        nxt_r.st    = skp_pkg::ST_UNIT;
        nxt_r.klen  = 4'h0;
        nxt_r.query = 1'b0;
        nxt_r.pkind = skp_pkg::PAR_NONE;
        nxt_r.num   = 16'h0000;
        if (is_nl) begin
          nxt_r.depth = 2'h0;
          nxt_r.base  = 2'h0;
        end else if (emit) begin
          // Next unit continues one level above the last keyword
          nxt_r.depth = nxt_r.depth - 2'h1;
          nxt_r.base  = nxt_r.depth;
        end else begin
          nxt_r.depth = r_ff.base;
        end
      end else if (fail) begin
        nxt_r.st = skp_pkg::ST_SKIP;
      end
    end

    // Error queue: head at slot 0, pop shifts, push appends
    if (err_pop && nxt_r.ecnt != 3'h0) begin
      for (int i = 0; i < 3; i++)
        nxt_r.eq[i] = nxt_r.eq[i+1];
      nxt_r.eq[3] = 8'h00;
      nxt_r.ecnt  = nxt_r.ecnt - 3'h1;
    end
    if (fail && nxt_r.ecnt != `SKP_EQ_DEPTH) begin
      nxt_r.eq[nxt_r.ecnt[1:0]] = errc;
      nxt_r.ecnt = nxt_r.ecnt + 3'h1;
    end
    nxt_r.rx_ready = !nxt_r.term_pend;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_ff          <= '0;
      r_ff.rx_ready <= 1'b1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign rx_ready     = r_ff.rx_ready;
  assign cmd_valid    = r_ff.cmd_valid;
  assign cmd_path     = r_ff.cmd_path;
  assign cmd_len      = r_ff.cmd_len;
  assign cmd_query    = r_ff.cmd_query;
  assign cmd_par_kind = r_ff.cmd_pkind;
  assign cmd_par_num  = r_ff.cmd_num;
  assign cal_mode     = r_ff.cal_mode;
  assign cal_store    = r_ff.cal_store;
  assign err_count    = r_ff.ecnt;
  assign err_head     = r_ff.eq[0];
endmodule : skp_parser

// file: dv/skp_host.sv
// Host controller model that sends text lines to the parser
`timescale 1ns/1ns
module skp_host (
  // Clock
  input  wire logic       clk,
  // Character port
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_char,
  output logic            rx_eol
);
  initial begin
    rx_valid = 1'b0;
    rx_char  = 8'h00;
    rx_eol   = 1'b0;
  end

  // A char is offered on a falling edge only when ready will be sampled
  task automatic send(input string s, input bit eol);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      while (rx_ready !== 1'b1) @(negedge clk);
      rx_valid = 1'b1;
      rx_char  = s[i];
      rx_eol   = eol && (i == s.len() - 1);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_eol   = 1'b0;
    // Released line shows no stale char
    rx_char  = ~rx_char;
  endtask : send
endmodule : skp_host

// file: dv/skp_parser_asserts.sv
// Port assertions for the text command parser
`timescale 1ns/1ns
module skp_parser_asserts (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Character stream
  input wire logic        rx_valid,
  input wire logic [7:0]  rx_char,
  input wire logic        rx_eol,
  input wire logic        rx_ready,
  // Decoded command
  input wire logic        cmd_valid,
  input wire logic [11:0] cmd_path,
  input wire logic [1:0]  cmd_len,
  input wire logic        cmd_query,
  input wire logic [1:0]  cmd_par_kind,
  input wire logic [15:0] cmd_par_num,
  // Calibration
  input wire logic        cal_mode,
  input wire logic        cal_store,
  // Error queue
  input wire logic        err_pop,
  input wire logic [2:0]  err_count,
  input wire logic [7:0]  err_head
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_eol_take;
    rx_valid && rx_ready && rx_eol && rx_char != 8'h0A;
  endsequence
  sequence s_gap;
    !rx_ready ##1 rx_ready;
  endsequence

  property p_eol_gap;
    s_eol_take |=> s_gap;
  endproperty
  a_eol_gap: assert property (p_eol_gap)
    else $error("ready gap missing after end-of-line char");

  property p_cmd_cause;
    cmd_valid |-> $past(rx_valid && rx_ready
      && (rx_char == 8'h0A || rx_char == 8'h3B))
      || $past(rx_valid && rx_ready && rx_eol, 2);
  endproperty
  a_cmd_cause: assert property (p_cmd_cause)
    else $error("command without a terminator or separator");

  property p_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("command strobe longer than one cycle");

  property p_len;
    cmd_valid |-> cmd_len != 2'h0 && cmd_par_kind != 2'h3;
  endproperty
  a_len: assert property (p_len)
    else $error("command with bad length or parameter kind");

  property p_store;
    cal_store |-> cmd_valid && cal_mode && cmd_len == 2'h2
      && cmd_path[7:0] == 8'hB1;
  endproperty
  a_store: assert property (p_store)
    else $error("store strobe without a save in calibration");

  property p_cal_open;
    $rose(cal_mode) |-> cmd_valid && cmd_path[3:0] == 4'h1
      && cmd_par_num == 16'h04D2;
  endproperty
  a_cal_open: assert property (p_cal_open)
    else $error("calibration opened without the access code");

  property p_err_max;
    err_count <= 3'h4;
  endproperty
  a_err_max: assert property (p_err_max)
    else $error("error queue above four");

  property p_pop;
    err_pop && err_count != 3'h0 |=> err_count == $past(err_count)
      || err_count == $past(err_count) - 3'h1;
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop did not shrink the error queue");

  property p_empty;
    err_count == 3'h0 |-> err_head == 8'h00;
  endproperty
  a_empty: assert property (p_empty)
    else $error("error head not zero while empty");

  property p_reset;
    $fell(sys_rst) |-> rx_ready && !cmd_valid && !cal_mode
      && err_count == 3'h0;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not at reset values");
endmodule : skp_parser_asserts

bind skp_parser skp_parser_asserts u_asserts (
  .clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
  .rx_char(rx_char), .rx_eol(rx_eol), .rx_ready(rx_ready),
  .cmd_valid(cmd_valid), .cmd_path(cmd_path), .cmd_len(cmd_len),
  .cmd_query(cmd_query), .cmd_par_kind(cmd_par_kind),
  .cmd_par_num(cmd_par_num), .cal_mode(cal_mode),
  .cal_store(cal_store), .err_pop(err_pop), .err_count(err_count),
  .err_head(err_head)
);

// file: dv/tb.sv
// Self-checking bench for the text command parser
`timescale 1ns/1ns
module tb;
  typedef struct {
    string       m;
    logic [11:0] p;
    logic [1:0]  l;
    logic        q;
    logic [1:0]  k;
    logic [15:0] v;
    logic [7:0]  e;
    int          n;
  } skp_row_t;

  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        err_pop = 1'b0;
  logic        rx_valid, rx_eol, rx_ready, cmd_valid, cmd_query;
  logic        cal_mode, cal_store;
  logic [7:0]  rx_char, err_head;
  logic [11:0] cmd_path;
  logic [1:0]  cmd_len, cmd_par_kind;
  logic [15:0] cmd_par_num;
  logic [2:0]  err_count;
  logic [11:0] mk;
  int          miscompares = 0;
  int          total_checks = 0;
  int          n_cmd = 0;
  int          n_store = 0;
  int          c;
  // Message, path, length, query, kind, number, error, units
  skp_row_t rows[14] = '{
    '{"VOLT 5\n", 12'h002, 2'h1, 1'h0, 2'h1, 16'h0005, 8'h00, 1},
    '{"voltage 12\n", 12'h002, 2'h1, 1'h0, 2'h1, 16'h000C, 8'h00, 1},
    '{"VOLT -12.5\n", 12'h002, 2'h1, 1'h0, 2'h1, 16'h007D, 8'h00, 1},
    '{"MEAS:VOLT?\n", 12'h024, 2'h2, 1'h1, 2'h0, 16'h0000, 8'h00, 1},
    '{"MEAS:VOLT?;CURR?\n", 12'h034, 2'h2, 1'h1, 2'h0, 16'h0, 8'h0, 2},
    '{"VOLT 1;:CURR 2\n", 12'h003, 2'h1, 1'h0, 2'h1, 16'h2, 8'h00, 2},
    '{":CURR:LEVEL 3\n", 12'h053, 2'h2, 1'h0, 2'h1, 16'h3, 8'h00, 1},
    '{"OutPut ON\n", 12'h006, 2'h1, 1'h0, 2'h2, 16'h0000, 8'h00, 1},
    '{"status?\n", 12'h007, 2'h1, 1'h1, 2'h0, 16'h0000, 8'h00, 1},
    '{"VOLT:LEVE\n", 12'h0, 2'h0, 1'h0, 2'h0, 16'h0, 8'h02, 0},
    '{"MEASU\n", 12'h0, 2'h0, 1'h0, 2'h0, 16'h0, 8'h02, 0},
    '{"VOLT?:LEV\n", 12'h0, 2'h0, 1'h0, 2'h0, 16'h0, 8'h03, 0},
    '{"VOLT 1;QQ;CURR 2\n", 12'h003, 2'h1, 1'h0, 2'h1, 16'h2, 8'h02, 2},
    '{"CAL:SAVE\n", 12'h0, 2'h0, 1'h0, 2'h0, 16'h0, 8'h05, 0}
  };

  always #50 clk = ~clk;

  always @(negedge clk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (cal_store === 1'b1) n_store++;
  end

  skp_parser dut (
    .clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_eol(rx_eol), .rx_ready(rx_ready),
    .cmd_valid(cmd_valid), .cmd_path(cmd_path), .cmd_len(cmd_len),
    .cmd_query(cmd_query), .cmd_par_kind(cmd_par_kind),
    .cmd_par_num(cmd_par_num), .cal_mode(cal_mode),
    .cal_store(cal_store), .err_pop(err_pop), .err_count(err_count),
    .err_head(err_head)
  );

  skp_host host (
    .clk(clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_eol(rx_eol)
  );

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic msg(input string m, input bit eol);
    host.send(m, eol);
    repeat (3) @(negedge clk);
  endtask : msg

  task automatic pop_err();
    err_pop = 1'b1;
    @(negedge clk);
    err_pop = 1'b0;
  endtask : pop_err

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    check("ready", 16'(rx_ready), 16'h0001);
    check("errs", 16'(err_count), 16'h0000);
    check("calmode", 16'(cal_mode), 16'h0000);
    check("valid", 16'(cmd_valid), 16'h0000);
  endtask : do_reset

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end

  initial begin
    do_reset();
    foreach (rows[i]) begin
      c = n_cmd;
      msg(rows[i].m, 1'b0);
      check("units", 16'(n_cmd - c), 16'(rows[i].n));
      if (rows[i].e !== 8'h00) begin
        check("err", 16'(err_head), 16'(rows[i].e));
        pop_err();
        check("errs", 16'(err_count), 16'h0000);
      end else begin
        mk = (rows[i].l == 2'h1) ? 12'h00F : 12'h0FF;
        check("path", 16'(cmd_path & mk), 16'(rows[i].p));
        check("len", 16'(cmd_len), 16'(rows[i].l));
        check("query", 16'(cmd_query), 16'(rows[i].q));
        check("kind", 16'(cmd_par_kind), 16'(rows[i].k));
        if (rows[i].k == 2'h1)
          check("num", cmd_par_num, rows[i].v);
      end
    end
    // Message closed by the end-of-line flag instead of a newline
    c = n_cmd;
    msg("TRIG", 1'b1);
    check("units", 16'(n_cmd - c), 16'h0001);
    check("path", 16'(cmd_path & 12'h00F), 16'h0009);
    // Each command on its own line with its full path
    msg("MEAS:CURR?\n", 1'b0);
    check("path", 16'(cmd_path & 12'h0FF), 16'h0034);
    check("query", 16'(cmd_query), 16'h0001);
    // Calibration gate: open, save, close
    msg("CAL 1234\n", 1'b0);
    check("calmode", 16'(cal_mode), 16'h0001);
    msg("cal:save\n", 1'b0);
    check("store", 16'(n_store), 16'h0001);
    msg("CAL 0\n", 1'b0);
    check("calmode", 16'(cal_mode), 16'h0000);
    // Overfill the error queue, pop one, then reset mid-run
    for (int i = 0; i < 5; i++) msg("X\n", 1'b0);
    check("errs", 16'(err_count), 16'h0004);
    pop_err();
    check("errs", 16'(err_count), 16'h0003);
    check("head", 16'(err_head), 16'h0002);
    msg("CAL 1234\n", 1'b0);
    do_reset();
    msg("VOLT 7\n", 1'b0);
    check("num", cmd_par_num, 16'h0007);
    stop_test();
  end
endmodule : tb
